// ---- shared/usm_defs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef USM_DEFS_SVH
`define USM_DEFS_SVH
`define USM_OFF_LINE_STATUS 32'h4000_8014
`define USM_OFF_MODEM_STATUS 32'h4000_8018
`define USM_OFF_SCRATCH 32'h4000_801c
`define USM_OFF_AUTOBAUD 32'h4000_8020
`define USM_OFF_MODEM_CTRL 32'h4000_8030
`define USM_OFF_FIFO_CTRL 32'h4000_8034
`define USM_OFF_CONFIG 32'h4000_8038
`define USM_OFF_DIVISOR 32'h4000_803c
`define USM_LSR_RX_FIFO_ERROR_SUMMARY_BIT 7
`define USM_LSR_TX_REJECT_ERROR_BIT 8
`define USM_MSR_STATE_LSB 4
`define USM_ACR_START_BIT 0
`define USM_ACR_MODE_BIT 1
`define USM_ACR_RESTART_BIT 2
`define USM_MCR_LOOP_BIT 4
`define USM_CFG_SC_BIT 0
`define USM_CFG_IRQEN_BIT 1
`define USM_CFG_RETRY_LSB 4
`define USM_RETRY_W 3
`define USM_SCRATCH_RST 8'h00
`define USM_PRESCALE 5'h10
`define USM_RATE_W 16
`endif

// ---- shared/usm_pkg.sv ----
// types shared by the status, modem and auto-baud register block
package usm_pkg;
  typedef enum logic [1:0] {
    USM_AB_IDLE = 2'b00,
    USM_AB_WAIT_FALL = 2'b01,
    USM_AB_COUNT = 2'b10
  } usm_ab_state_t;
endpackage

// ---- src/usm_autobaud.sv ----
// auto-baud rate measurement engine
`timescale 1ns/1ps
`include "usm_defs.svh"
module usm_autobaud
  import usm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic mode_in,
  input wire logic restart_en_in,
  input wire logic rx_in,
  output logic busy_out,
  output logic done_out,
  output logic timeout_out,
  output logic [`USM_RATE_W-1:0] count_out
);
  usm_ab_state_t state, next_state;
  logic [`USM_RATE_W-1:0] count, next_count;
  logic [4:0] pre, next_pre;
  logic rx_d, done, next_done, tout, next_tout;
  logic fall, rise, tick;

  // rx_in is already synchronised by the caller
  assign fall = rx_d & ~rx_in;
  assign rise = ~rx_d & rx_in;
  assign tick = (pre == `USM_PRESCALE - 5'h01);
  assign busy_out = (state != USM_AB_IDLE);
  assign done_out = done;
  assign timeout_out = tout;
  assign count_out = count;

  // measurement sequence; stop by software wins over every next-state choice, but a done or time-out pulse in that cycle still fires
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_pre = tick ? 5'h00 : pre + 5'h01;
    next_done = 1'b0;
    next_tout = 1'b0;
    case (state)
      USM_AB_IDLE:
      begin
        if (start_in)
        begin
          next_state = USM_AB_WAIT_FALL;
          next_count = '0;
        end
      end
      USM_AB_WAIT_FALL:
      begin
        next_pre = 5'h00;
        if (fall)
          next_state = USM_AB_COUNT;
      end
      USM_AB_COUNT:
      begin
        // mode 0 ends on next falling edge, mode 1 on rising edge
        if ((mode_in && rise) || (!mode_in && fall)) // see RULE17
        begin
          next_state = USM_AB_IDLE;
          next_done = 1'b1;
        end
        else if (tick && (&count)) // see RULE18
        begin
          next_tout = 1'b1;
          next_count = '0;
          next_state = restart_en_in ? USM_AB_WAIT_FALL : USM_AB_IDLE; // see RULE15
        end
        else if (tick)
          next_count = count + `USM_RATE_W'(1);
      end
      default:
        next_state = USM_AB_IDLE;
    endcase
    if (stop_in)
      next_state = USM_AB_IDLE;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state <= USM_AB_IDLE;
      count <= '0;
      pre <= 5'h00;
      rx_d <= 1'b1;
      done <= 1'b0;
      tout <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      pre <= next_pre;
      rx_d <= rx_in;
      done <= next_done;
      tout <= next_tout;
    end
  end

  property p_timeout_path;
    @(posedge clk_in) disable iff (!rst_b_in)
    (state == USM_AB_COUNT && tick && (&count) && !rise && !fall && !stop_in)
    |=> tout && (state == ($past(restart_en_in) ? USM_AB_WAIT_FALL : USM_AB_IDLE));
  endproperty
  a_timeout_path: assert property (p_timeout_path) else $error("timeout handling wrong"); // see RULE15

  property p_mode1_end;
    @(posedge clk_in) disable iff (!rst_b_in)
    (state == USM_AB_COUNT && mode_in && rise && !stop_in) |=> done && state == USM_AB_IDLE;
  endproperty
  a_mode1_end: assert property (p_mode1_end) else $error("mode 1 did not end on rise"); // see RULE17
endmodule

// ---- src/usm_regs.sv ----
// line/modem status, scratch and auto-baud control registers on avalon-mm
// Functional notes
// RULE1 - errored char into fifo sets error summary
// RULE2 - status read clears summary unless errors remain
// RULE3 - smart card reject beyond retries sets error
// RULE4 - cts change sets flag, read clears
// RULE5 - dsr change sets flag, read clears
// RULE6 - ri low-to-high sets flag, read clears
// RULE7 - dcd change sets flag, read clears
// RULE8 - bit4 is inverted cts or loopback bit1
// RULE9 - bit5 is inverted dsr or loopback bit0
// RULE10 - bit6 is inverted ri or loopback bit2
// RULE11 - bit7 is inverted dcd or loopback bit3
// RULE12 - scratch byte read/write, resets zero, no effect
// RULE13 - start bit runs, self-clears on completion
// RULE14 - mode bit selects measurement mode
// RULE15 - auto-restart on time-out at next fall
// RULE16 - software keeps reserved control bits zero
// RULE17 - mode0 fall-to-fall, mode1 fall-to-rise
// RULE18 - counter overflow means measurement time-out
// RULE19 - done loads divisor, raises enabled irq
// RULE20 - new modem event beats read clear
// RULE21 - reserved bits read zero, status writes ignored
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "usm_defs.svh"
module usm_regs
  import usm_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [31:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic cts_b_in,
  input wire logic dsr_b_in,
  input wire logic ri_b_in,
  input wire logic dcd_b_in,
  input wire logic rx_in,
  input wire logic rx_err_load_in,
  input wire logic rx_err_remaining_in,
  input wire logic tx_nack_in,
  input wire logic tx_char_start_in,
  output logic [15:0] divisor_out,
  output logic divisor_load_out,
  output logic autobaud_done_irq_out,
  output logic autobaud_timeout_out,
  output logic autobaud_busy_out
);
  // address match, used by the read mux and by every write strobe
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] off);
    hit = (addr == off);
  endfunction

  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic rd_acc, wr_acc;
  logic [3:0] pin_s1, pin_s2;
  logic [1:0] rx_s;
  logic [3:0] state_bits, state_prev, delta, next_delta, ev;
  logic rx_fifo_error_summary, next_rx_fifo_error_summary, tx_reject_error, next_tx_reject_error;
  logic [3:0] nacks, next_nacks;
  logic [7:0] scratch, next_scratch;
  logic mode, next_mode, restart, next_restart;
  logic [4:0] mctl, next_mctl;
  logic fifo_en, next_fifo_en;
  logic [7:0] cfg, next_cfg;
  logic [15:0] divisor, next_divisor;
  logic ab_start, ab_stop, ab_busy, ab_done, ab_tout;
  logic [15:0] ab_count;
  logic loop;
  logic [`USM_RETRY_W-1:0] retry;

  // one wait state: the access is taken at the edge where ack is high
  assign rd_acc = avs_read_in & ack;
  assign wr_acc = avs_write_in & ack & avs_byteenable_in[0];
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
  assign avs_readdata_out = rdata;
  assign loop = mctl[`USM_MCR_LOOP_BIT];
  assign retry = cfg[`USM_CFG_RETRY_LSB +: `USM_RETRY_W];

  // pin order in vectors: 0 cts, 1 dsr, 2 ri, 3 dcd; state is active high
  always_comb
  begin
    state_bits = ~pin_s2;
    if (loop)
      state_bits = {mctl[3], mctl[2], mctl[0], mctl[1]}; // see RULE8 RULE9 RULE10 RULE11
  end

  // change detect per modem line; ri only counts its trailing edge
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_delta
      if (g == 2)
      begin : g_ring
        assign ev[g] = state_prev[g] & ~state_bits[g]; // see RULE6
      end
      else
      begin : g_any
        assign ev[g] = state_prev[g] ^ state_bits[g]; // see RULE4 RULE5 RULE7
      end
      // set wins over a read in the same cycle
      assign next_delta[g] = ev[g] | (delta[g] &
        ~(rd_acc & hit(avs_address_in, `USM_OFF_MODEM_STATUS))); // see RULE20
    end
  endgenerate

  // auto-baud command strobes from a write to the control register
  assign ab_start = wr_acc & hit(avs_address_in, `USM_OFF_AUTOBAUD)
                    & avs_writedata_in[`USM_ACR_START_BIT]; // see RULE13
  assign ab_stop = wr_acc & hit(avs_address_in, `USM_OFF_AUTOBAUD)
                   & ~avs_writedata_in[`USM_ACR_START_BIT];

  usm_autobaud u_ab (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .start_in(ab_start),
    .stop_in(ab_stop),
    .mode_in(mode),
    .restart_en_in(restart),
    .rx_in(rx_s[1]),
    .busy_out(ab_busy),
    .done_out(ab_done),
    .timeout_out(ab_tout),
    .count_out(ab_count)
  );

  // status flags, control bits and read mux
  always_comb
  begin
    next_ack = (avs_read_in | avs_write_in) & ~ack;
    next_rdata = rdata;
    next_rx_fifo_error_summary = rx_fifo_error_summary;
    next_tx_reject_error = tx_reject_error;
    next_nacks = nacks;
    next_scratch = scratch;
    next_mode = mode;
    next_restart = restart;
    next_mctl = mctl;
    next_fifo_en = fifo_en;
    next_cfg = cfg;
    next_divisor = divisor;
    // summary clears only when nothing errored is left behind; reject error clears on every read
    if (rd_acc && hit(avs_address_in, `USM_OFF_LINE_STATUS))
    begin
      if (!rx_err_remaining_in)
        next_rx_fifo_error_summary = 1'b0; // see RULE2
      next_tx_reject_error = 1'b0;
    end
    if (rx_err_load_in && fifo_en)
      next_rx_fifo_error_summary = 1'b1; // see RULE1
    // one nack beyond the retry budget flags the character
    if (tx_char_start_in)
      next_nacks = 4'h0;
    else if (tx_nack_in && cfg[`USM_CFG_SC_BIT])
    begin
      next_nacks = nacks + 4'h1;
      if (nacks == {1'b0, retry})
        next_tx_reject_error = 1'b1; // see RULE3
    end
    // status registers take no writes
    if (wr_acc)
    begin
      if (hit(avs_address_in, `USM_OFF_SCRATCH))
        next_scratch = avs_writedata_in[7:0]; // see RULE12
      if (hit(avs_address_in, `USM_OFF_AUTOBAUD))
      begin
        next_mode = avs_writedata_in[`USM_ACR_MODE_BIT]; // see RULE14
        next_restart = avs_writedata_in[`USM_ACR_RESTART_BIT];
      end
      if (hit(avs_address_in, `USM_OFF_MODEM_CTRL))
        next_mctl = avs_writedata_in[4:0];
      if (hit(avs_address_in, `USM_OFF_FIFO_CTRL))
        next_fifo_en = avs_writedata_in[0];
      if (hit(avs_address_in, `USM_OFF_CONFIG))
        next_cfg = avs_writedata_in[7:0];
      if (hit(avs_address_in, `USM_OFF_DIVISOR) && avs_byteenable_in[1])
        next_divisor = avs_writedata_in[15:0];
    end
    // measured count lands in the divisor latch pair
    if (ab_done)
      next_divisor = ab_count; // see RULE19
    // data is sampled on the edge that raises ack, stable while it is high
    if (next_ack)
    begin
      next_rdata = 32'h0000_0000; // see RULE21
      if (hit(avs_address_in, `USM_OFF_LINE_STATUS))
      begin
        next_rdata[`USM_LSR_RX_FIFO_ERROR_SUMMARY_BIT] = rx_fifo_error_summary & fifo_en; // see RULE1
        next_rdata[`USM_LSR_TX_REJECT_ERROR_BIT] = tx_reject_error;
      end
      if (hit(avs_address_in, `USM_OFF_MODEM_STATUS))
        next_rdata[7:0] = {state_bits[3], state_bits[2], state_bits[1], state_bits[0],
                           delta[3], delta[2], delta[1], delta[0]};
      if (hit(avs_address_in, `USM_OFF_SCRATCH))
        next_rdata[7:0] = scratch;
      // reserved control bits read zero regardless of what was written
      if (hit(avs_address_in, `USM_OFF_AUTOBAUD))
        next_rdata[2:0] = {restart, mode, ab_busy}; // see RULE13 RULE16
      if (hit(avs_address_in, `USM_OFF_MODEM_CTRL))
        next_rdata[4:0] = mctl;
      if (hit(avs_address_in, `USM_OFF_FIFO_CTRL))
        next_rdata[0] = fifo_en;
      if (hit(avs_address_in, `USM_OFF_CONFIG))
        next_rdata[7:0] = cfg;
      if (hit(avs_address_in, `USM_OFF_DIVISOR))
        next_rdata[15:0] = divisor;
    end
  end

  // data outputs from flops; busy is decoded from the engine state flops
  assign divisor_out = divisor;
  assign autobaud_busy_out = ab_busy;
  assign autobaud_timeout_out = ab_tout;

  // strobe outputs, one cycle after the engine reports
  logic load_q, irq_q;
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      load_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      load_q <= ab_done;
      irq_q <= ab_done & cfg[`USM_CFG_IRQEN_BIT]; // see RULE19
    end
  end
  assign divisor_load_out = load_q;
  assign autobaud_done_irq_out = irq_q;

  // pins pass two flops before anything looks at them
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pin_s1 <= 4'hf;
      pin_s2 <= 4'hf;
      rx_s <= 2'h3;
      state_prev <= 4'h0;
    end
    else
    begin
      pin_s1 <= {dcd_b_in, ri_b_in, dsr_b_in, cts_b_in};
      pin_s2 <= pin_s1;
      rx_s <= {rx_s[0], rx_in};
      state_prev <= state_bits;
    end
  end

  // register file
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      delta <= 4'h0;
      rx_fifo_error_summary <= 1'b0;
      tx_reject_error <= 1'b0;
      nacks <= 4'h0;
      scratch <= `USM_SCRATCH_RST;
      mode <= 1'b0;
      restart <= 1'b0;
      mctl <= 5'h00;
      fifo_en <= 1'b0;
      cfg <= 8'h00;
      divisor <= 16'h0000;
    end
    else
    begin
      ack <= next_ack;
      rdata <= next_rdata;
      delta <= next_delta;
      rx_fifo_error_summary <= next_rx_fifo_error_summary;
      tx_reject_error <= next_tx_reject_error;
      nacks <= next_nacks;
      scratch <= next_scratch;
      mode <= next_mode;
      restart <= next_restart;
      mctl <= next_mctl;
      fifo_en <= next_fifo_en;
      cfg <= next_cfg;
      divisor <= next_divisor;
    end
  end

  // checks
  sequence s_msr_read;
    rd_acc && hit(avs_address_in, `USM_OFF_MODEM_STATUS);
  endsequence

  property p_rx_fifo_error_summary_set;
    @(posedge clk_in) disable iff (!rst_b_in)
    rx_err_load_in && fifo_en |=> rx_fifo_error_summary;
  endproperty
  a_rx_fifo_error_summary_set: assert property (p_rx_fifo_error_summary_set) else $error("error summary not set"); // see RULE1

  property p_rx_fifo_error_summary_hold;
    @(posedge clk_in) disable iff (!rst_b_in)
    rx_fifo_error_summary && rx_err_remaining_in |=> rx_fifo_error_summary;
  endproperty
  a_rx_fifo_error_summary_hold: assert property (p_rx_fifo_error_summary_hold) else $error("error summary lost"); // see RULE2

  property p_cts_delta;
    @(posedge clk_in) disable iff (!rst_b_in)
    !loop && !$past(loop) && $changed(pin_s2[0]) |=> delta[0];
  endproperty
  a_cts_delta: assert property (p_cts_delta) else $error("cts change missed"); // see RULE4

  property p_ring_edge;
    @(posedge clk_in) disable iff (!rst_b_in)
    !loop && !$past(loop) && $rose(pin_s2[2]) |=> delta[2];
  endproperty
  a_ring_edge: assert property (p_ring_edge) else $error("ring edge missed"); // see RULE6

  property p_msr_clear;
    @(posedge clk_in) disable iff (!rst_b_in)
    s_msr_read ##0 (ev == 4'h0) |=> delta == 4'h0;
  endproperty
  a_msr_clear: assert property (p_msr_clear) else $error("delta not cleared"); // see RULE7

  property p_set_wins;
    @(posedge clk_in) disable iff (!rst_b_in)
    s_msr_read ##0 ev[3] |=> delta[3];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to read"); // see RULE20

  property p_cts_state;
    @(posedge clk_in) disable iff (!rst_b_in)
    $rose(ack) && avs_read_in && hit(avs_address_in, `USM_OFF_MODEM_STATUS) && !$past(loop)
    |-> avs_readdata_out[`USM_MSR_STATE_LSB] == ~$past(pin_s2[0]);
  endproperty
  a_cts_state: assert property (p_cts_state) else $error("cts state wrong"); // see RULE8

  property p_scratch;
    @(posedge clk_in) disable iff (!rst_b_in)
    wr_acc && hit(avs_address_in, `USM_OFF_SCRATCH) |=> scratch == $past(avs_writedata_in[7:0]);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch not written"); // see RULE12

  property p_done_load;
    @(posedge clk_in) disable iff (!rst_b_in)
    ab_done |=> divisor == $past(ab_count) ##0 divisor_load_out;
  endproperty
  a_done_load: assert property (p_done_load) else $error("divisor not loaded"); // see RULE19
endmodule

// ---- testbench/usm_line_model.sv ----
// partner model: modem control lines and serial receive line of the far end
`timescale 1ns/1ps
module usm_line_model
(
  input wire logic clk_in,
  output logic cts_b_out,
  output logic dsr_b_out,
  output logic ri_b_out,
  output logic dcd_b_out,
  output logic rx_out
);
  logic [3:0] pins_b;

  // all lines rest inactive high, the serial line idles high
  initial
  begin
    pins_b = 4'hf;
    rx_out = 1'b1;
  end

  // pin order cts, dsr, ri, dcd
  assign cts_b_out = pins_b[0];
  assign dsr_b_out = pins_b[1];
  assign ri_b_out = pins_b[2];
  assign dcd_b_out = pins_b[3];

  // change one modem line right after a clock edge
  task automatic set_pin(input int idx, input logic lvl);
    pins_b[idx] <= lvl;
  endtask

  // start bit of low1 cycles, then optional high and second low, then idle
  task automatic send_rx(input int low1, input int high1, input int low2);
    rx_out <= 1'b0;
    repeat (low1) @(posedge clk_in);
    if (high1 > 0)
    begin
      rx_out <= 1'b1;
      repeat (high1) @(posedge clk_in);
      rx_out <= 1'b0;
      repeat (low2) @(posedge clk_in);
    end
    rx_out <= 1'b1;
    @(posedge clk_in);
  endtask
endmodule

// ---- testbench/test_usm_regs.sv ----
// self-checking bench for the status, modem and auto-baud register block
`timescale 1ns/1ps
`include "usm_defs.svh"
module test_usm_regs;
  import usm_pkg::*;
  logic clk_in, rst_b_in, avs_read, avs_write, rx;
  logic [31:0] avs_address, avs_writedata, avs_readdata_out, scratch;
  logic avs_waitrequest_out, cts_b, dsr_b, ri_b, dcd_b, rx_err_remaining;
  logic [2:0] strobes; // err load, nack, char start
  logic [15:0] divisor_out;
  logic divisor_load_out, autobaud_done_irq_out, autobaud_timeout_out, autobaud_busy_out;
  int errors, checked;

  usm_regs DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(avs_address), .avs_read_in(avs_read),
    .avs_write_in(avs_write), .avs_writedata_in(avs_writedata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .cts_b_in(cts_b),
    .dsr_b_in(dsr_b), .ri_b_in(ri_b), .dcd_b_in(dcd_b), .rx_in(rx), .rx_err_load_in(strobes[0]),
    .rx_err_remaining_in(rx_err_remaining), .tx_nack_in(strobes[1]), .tx_char_start_in(strobes[2]),
    .divisor_out(divisor_out), .divisor_load_out(divisor_load_out), .autobaud_done_irq_out(autobaud_done_irq_out),
    .autobaud_timeout_out(autobaud_timeout_out), .autobaud_busy_out(autobaud_busy_out));

  usm_line_model m (.clk_in(clk_in), .cts_b_out(cts_b), .dsr_b_out(dsr_b), .ri_b_out(ri_b), .dcd_b_out(dcd_b),
    .rx_out(rx));

  // 200 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one avalon access; request held until waitrequest is seen low at a rising edge
  task automatic bus_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 50);
    rd = avs_readdata_out;
    if (n >= 50)
      check("waitrequest", 32'h1, 32'h0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus_xfer(1'b1, a, d, dummy);
  endtask

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus_xfer(1'b0, a, 32'h0, v);
    check(name, v, exp);
  endtask

  // n single-cycle strobes on one of the status event inputs
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      strobes[idx] <= 1'b1;
      @(posedge clk_in);
      strobes[idx] <= 1'b0;
      @(posedge clk_in);
    end
  endtask

  // bounded wait for the divisor load strobe, then judge outputs in that cycle
  task automatic wait_load(input logic irq_exp);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (divisor_load_out !== 1'b1 && n < 400);
    check("divisor load", {31'h0, divisor_load_out}, 32'h1);
    check("done irq", {31'h0, autobaud_done_irq_out}, {31'h0, irq_exp});
    check("busy after done", {31'h0, autobaud_busy_out}, 32'h0);
    check("divisor near 10", {31'h0, (divisor_out >= 16'h0009 && divisor_out <= 16'h000b)}, 32'h1);
    scratch = {16'h0, divisor_out};
    @(posedge clk_in);
    rd_chk("divisor reg", `USM_OFF_DIVISOR, scratch);
  endtask

  // hang guard, far beyond the fewer than a thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_in);
    errors++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    errors = 0;
    checked = 0;
    rst_b_in = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 32'h0;
    avs_writedata = 32'h0;
    strobes = 3'h0;
    rx_err_remaining = 1'b0;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    // reset values, scratch byte, unmapped and read-only places
    rd_chk("scratch reset", `USM_OFF_SCRATCH, 32'h0);
    rd_chk("modem reset", `USM_OFF_MODEM_STATUS, 32'h0);
    rd_chk("autobaud reset", `USM_OFF_AUTOBAUD, 32'h0);
    wr(`USM_OFF_SCRATCH, 32'hffff_ffa5);
    rd_chk("scratch", `USM_OFF_SCRATCH, 32'h0000_00a5);
    rd_chk("unmapped", 32'h4000_8028, 32'h0);
    wr(`USM_OFF_LINE_STATUS, 32'h0000_01ff);
    rd_chk("line write ignored", `USM_OFF_LINE_STATUS, 32'h0);
    // each modem line: low then back high; ring flags only its trailing edge
    for (int i = 0; i < 4; i++)
    begin
      m.set_pin(i, 1'b0);
      repeat (6) @(posedge clk_in);
      rd_chk("modem low", `USM_OFF_MODEM_STATUS, ((i == 2) ? 32'h0 : (32'h1 << i)) | (32'h10 << i));
      m.set_pin(i, 1'b1);
      repeat (6) @(posedge clk_in);
      rd_chk("modem high", `USM_OFF_MODEM_STATUS, (i == 2) ? 32'h4 : (32'h1 << i));
      rd_chk("modem cleared", `USM_OFF_MODEM_STATUS, 32'h0);
    end
    // loopback: states follow modem control, pins ignored
    wr(`USM_OFF_MODEM_CTRL, 32'h12);
    repeat (4) @(posedge clk_in);
    rd_chk("loop cts", `USM_OFF_MODEM_STATUS, 32'h11);
    wr(`USM_OFF_MODEM_CTRL, 32'h1d);
    repeat (4) @(posedge clk_in);
    rd_chk("loop others", `USM_OFF_MODEM_STATUS, 32'heb);
    wr(`USM_OFF_MODEM_STATUS, 32'hff);
    m.set_pin(0, 1'b0);
    repeat (6) @(posedge clk_in);
    rd_chk("loop pin ignored", `USM_OFF_MODEM_STATUS, 32'he0);
    m.set_pin(0, 1'b1);
    repeat (6) @(posedge clk_in);
    wr(`USM_OFF_MODEM_CTRL, 32'h0);
    repeat (4) @(posedge clk_in);
    rd_chk("loop exit", `USM_OFF_MODEM_STATUS, 32'h0e);
    // receive error summary: masked while fifo off, held while errors remain
    pulse(0, 1);
    rd_chk("rx_fifo_error_summary fifo off", `USM_OFF_LINE_STATUS, 32'h0);
    wr(`USM_OFF_FIFO_CTRL, 32'h1);
    rx_err_remaining <= 1'b1;
    pulse(0, 1);
    rd_chk("rx_fifo_error_summary set", `USM_OFF_LINE_STATUS, 32'h80);
    rd_chk("rx_fifo_error_summary held", `USM_OFF_LINE_STATUS, 32'h80);
    rx_err_remaining <= 1'b0;
    rd_chk("rx_fifo_error_summary last", `USM_OFF_LINE_STATUS, 32'h80);
    rd_chk("rx_fifo_error_summary cleared", `USM_OFF_LINE_STATUS, 32'h0);
    // smart card, retry count 2: third reject of one character flags
    wr(`USM_OFF_CONFIG, 32'h21);
    pulse(2, 1);
    pulse(1, 2);
    rd_chk("tx_reject_error retries", `USM_OFF_LINE_STATUS, 32'h0);
    pulse(1, 1);
    rd_chk("tx_reject_error set", `USM_OFF_LINE_STATUS, 32'h100);
    pulse(2, 1);
    pulse(1, 2);
    rd_chk("tx_reject_error new char", `USM_OFF_LINE_STATUS, 32'h0);
    // mode 1: start bit of 160 clocks is ten prescaled counts
    wr(`USM_OFF_CONFIG, 32'h2);
    wr(`USM_OFF_AUTOBAUD, 32'h3);
    rd_chk("autobaud running", `USM_OFF_AUTOBAUD, 32'h3);
    fork
      m.send_rx(160, 0, 0);
      wait_load(1'b1);
    join
    rd_chk("autobaud done", `USM_OFF_AUTOBAUD, 32'h2);
    // mode 0: fall to fall over 160 clocks, irq disabled
    wr(`USM_OFF_CONFIG, 32'h0);
    wr(`USM_OFF_AUTOBAUD, 32'h1);
    // load pulse lands while the line is still low, so watch it alongside
    fork
      m.send_rx(80, 80, 80);
      wait_load(1'b0);
    join
    // stop by writing zero; restart bit reads back
    wr(`USM_OFF_AUTOBAUD, 32'h1);
    check("busy", {31'h0, autobaud_busy_out}, 32'h1);
    wr(`USM_OFF_AUTOBAUD, 32'h0);
    rd_chk("autobaud stopped", `USM_OFF_AUTOBAUD, 32'h0);
    wr(`USM_OFF_AUTOBAUD, 32'h6);
    rd_chk("restart bit", `USM_OFF_AUTOBAUD, 32'h6);
    check("no timeout", {31'h0, autobaud_timeout_out}, 32'h0);
    tally_and_finish();
  end
endmodule
